// File: ptm_pkg.sv
/*
 Shared constants for the pulse timer module: register map, field
 positions, encodings and the byte merge used by 16-bit registers.
 Assumes a 32-bit AXI4-Lite register bus with byte addresses.
*/
package ptm_pkg;

	localparam int          AXI_AW       = 8;
	localparam int          CNT_W        = 16;
	localparam int          NCH_MAX      = 8;

	// Register byte addresses
	localparam logic [7:0]  ADDR_SC      = 8'h00;
	localparam logic [7:0]  ADDR_CNT     = 8'h04;
	localparam logic [7:0]  ADDR_MOD     = 8'h08;
	localparam logic [7:0]  ADDR_CH_BASE = 8'h10;
	localparam logic [2:0]  CH_CTRL_OFS  = 3'h0;
	localparam logic [2:0]  CH_VAL_OFS   = 3'h4;

	// Status and control fields
	localparam int          SC_TOF       = 7;
	localparam int          SC_TOIE      = 6;
	localparam int          SC_CENTER_ALIGN_SELECT     = 5;
	localparam int          SC_CLKS_LSB  = 3;
	localparam int          SC_PS_LSB    = 0;

	// Channel control fields
	localparam int          CH_FLAG      = 7;
	localparam int          CH_IE        = 6;
	localparam int          CH_MS_LSB    = 4;
	localparam int          CH_ELS_LSB   = 2;

	// Encodings
	localparam logic [1:0]  CS_OFF       = 2'h0;
	localparam logic [1:0]  CS_BUS       = 2'h1;
	localparam logic [1:0]  CS_FIX       = 2'h2;
	localparam logic [1:0]  CS_EXT       = 2'h3;
	localparam logic [1:0]  MS_IC        = 2'h0;
	localparam logic [1:0]  MS_OC        = 2'h1;
	localparam logic [1:0]  ELS_OFF      = 2'h0;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [15:0] CNT_ZERO     = 16'h0000;
	localparam logic [15:0] CNT_FULL     = 16'hFFFF;

	typedef enum logic [1:0] {
		DIR_UP   = 2'b01,
		DIR_DOWN = 2'b10
	} ptm_dir_t;

	function automatic logic [15:0] ptm_merge16(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] strb);
		ptm_merge16 = {strb[1] ? new_v[15:8] : old_v[15:8],
			strb[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

endpackage

// File: ptm_chan.sv
/*
 One timer channel: input capture, output compare, edge- and
 center-aligned PWM, its value register, flag and pin control.
 Assumes the counter update pulse and count come from the top level.
*/
`timescale 1ns/1ps
module ptm_chan
	import ptm_pkg::*;
(
	// Clock and reset
	input  logic        aclk,
	input  logic        aresetn,
	// Counter view
	input  logic [15:0] count_value,
	input  logic        count_upd,
	input  logic        step_up,
	input  logic        center,
	input  logic        clock_on,
	// Configuration
	input  logic [1:0]  mode,
	input  logic [1:0]  els,
	input  logic        val_wr,
	input  logic [15:0] val_wdata,
	input  logic [1:0]  val_wstrb,
	input  logic        flag_clr,
	// Pin
	input  logic        pin_in,
	output logic        pin_out,
	output logic        pin_oe_n,
	// Status
	output logic [15:0] chan_value,
	output logic        chan_flag
);

	logic [15:0] value_r;
	logic        flag_r;
	logic        out_r;
	logic        out_nxt;
	logic        pin_d_r;

	wire els_on = (els != ELS_OFF);
	wire is_ic  = !center && (mode == MS_IC);
	wire is_oc  = !center && (mode == MS_OC);
	wire is_ep  = !center && mode[1];
	wire match  = count_upd && (count_value == value_r);
	wire start  = count_upd && (count_value == CNT_ZERO);
	wire rise   = pin_in && !pin_d_r;
	wire fall   = !pin_in && pin_d_r;
	wire cap    = is_ic && ((els[0] && rise) || (els[1] && fall));
	wire evt    = cap || (match && !is_ic);

	// Match beats period start so a zero value gives zero duty
	always_comb begin
		out_nxt = out_r;
		if (center) begin
			if (match)
				out_nxt = step_up ? els[0] : ~els[0];
		end else if (is_ep) begin
			if (match)
				out_nxt = els[0];
			else if (start)
				out_nxt = ~els[0];
		end else if (is_oc && match) begin
			case (els)
				2'h1: out_nxt = ~out_r;
				2'h2: out_nxt = 1'b0;
				2'h3: out_nxt = 1'b1;
				default: out_nxt = out_r;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			value_r <= 16'h0000;
			flag_r  <= 1'b0;
			out_r   <= 1'b0;
			pin_d_r <= 1'b0;
		end else begin
			pin_d_r <= pin_in;
			out_r   <= out_nxt;
			flag_r  <= evt || (flag_r && !flag_clr);
			if (val_wr)
				value_r <= ptm_merge16(value_r, val_wdata, val_wstrb);
			else if (cap)
				value_r <= count_value;
		end
	end

	assign pin_out    = out_r;
	assign pin_oe_n   = !(clock_on && els_on && !is_ic);
	assign chan_value = value_r;
	assign chan_flag  = flag_r;

	////////////////////////////////////////////////////////////////////////
	a_cap_copy: assert property (@(posedge aclk) disable iff (!aresetn)
		(cap && !val_wr) |=> (value_r == $past(count_value)) && flag_r)
		else $error("capture did not copy count");
	a_oc_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(is_oc && match) |=> flag_r)
		else $error("compare match did not set flag");
	a_edge_aligned_pwm_lead: assert property (@(posedge aclk) disable iff (!aresetn)
		(is_ep && els_on && start && !match) |=> (out_r == ~$past(els[0])))
		else $error("pwm leading edge missing at period start");

endmodule

// File: ptm_top.sv
/*
 Pulse timer module: 16-bit counter with prescaler and modulo, clock
 source selection, NCH channels and an AXI4-Lite register slave.
 Assumes pin inputs synchronous to aclk; the caller resolves pin drive.
*/
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module ptm_top
	import ptm_pkg::*;
#(
	parameter int NCH = 8
)
(
	// Clock and reset
	input  logic              aclk,
	input  logic              aresetn,
	// AXI4-Lite write
	input  logic [AXI_AW-1:0] awaddr,
	input  logic              awvalid,
	output logic              awready,
	input  logic [31:0]       wdata,
	input  logic [3:0]        wstrb,
	input  logic              wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  logic              bready,
	// AXI4-Lite read
	input  logic [AXI_AW-1:0] araddr,
	input  logic              arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  logic              rready,
	// Clock sources and debug
	input  logic              fixed_clk_in,
	input  logic              external_count_clock,
	input  logic              background_debug_mode,
	// Channel pins
	input  logic [NCH-1:0]    pin_in,
	output logic [NCH-1:0]    channel_pin,
	output logic [NCH-1:0]    channel_pin_oe_n,
	// Interrupt requests
	output logic [NCH-1:0]    chan_irq,
	output logic              tc_irq
);

	if (NCH < 1 || NCH > NCH_MAX) begin : g_chk
		$error("ptm_top: NCH must be 1 to 8");
	end

	////////////////////////////////////////////////////////////////////////
	// Bus slave state

	logic [AXI_AW-1:0] awaddr_r;
	logic              aw_have_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              w_have_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	logic              rvalid_r;
	logic [31:0]       rdata_r;
	logic [1:0]        rresp_r;

	// Global control and counter state
	logic              tof_r;
	logic              toie_r;
	logic              center_align_select_r;
	logic [1:0]        clks_r;
	logic [2:0]        ps_r;
	logic [15:0]       mod_r;
	logic [15:0]       cnt_r;
	logic [15:0]       cnt_nxt;
	ptm_dir_t          dir_r;
	ptm_dir_t          dir_nxt;
	logic [6:0]        pre_r;
	logic              upd_r;
	logic              step_up_r;
	logic [2:0]        fix_s_r;
	logic [2:0]        ext_s_r;

	logic [NCH-1:0]    ch_wr_ctrl;
	logic [NCH-1:0]    ch_wr_val;
	logic [NCH-1:0]    ch_rd_hit;
	logic [31:0]       ch_rd_data [NCH];
	logic [31:0]       rd_mux;

	////////////////////////////////////////////////////////////////////////
	// Write decode; one write at a time, taken once both halves arrived

	assign awready = !aw_have_r && !bvalid_r;
	assign wready  = !w_have_r && !bvalid_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;

	wire        do_wr   = aw_have_r && w_have_r && !bvalid_r;
	wire        w_sc    = (awaddr_r == ADDR_SC);
	wire        w_cnt   = (awaddr_r == ADDR_CNT);
	wire        w_mod   = (awaddr_r == ADDR_MOD);
	wire        w_hit   = w_sc || w_cnt || w_mod || (|ch_wr_ctrl) || (|ch_wr_val);
	wire        cnt_wr  = do_wr && w_cnt;
	wire        sc_wr   = do_wr && w_sc && wstrb_r[0];
	wire [15:0] wd16    = wdata_r[15:0];
	wire [1:0]  ws16    = wstrb_r[1:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				aw_have_r <= 1'b1;
				awaddr_r  <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_r <= 1'b1;
				wdata_r  <= wdata;
				wstrb_r  <= wstrb;
			end
			if (do_wr) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= w_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read path: no read has any side effect on the timer

	wire r_sc  = (araddr == ADDR_SC);
	wire r_cnt = (araddr == ADDR_CNT);
	wire r_mod = (araddr == ADDR_MOD);
	wire r_hit = r_sc || r_cnt || r_mod || (|ch_rd_hit);

	assign arready = !rvalid_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;

	always_comb begin
		rd_mux = 32'h00000000;
		if (r_sc)
			rd_mux = {24'h000000, tof_r, toie_r, center_align_select_r, clks_r, ps_r};
		if (r_cnt)
			rd_mux = {16'h0000, cnt_r};
		if (r_mod)
			rd_mux = {16'h0000, mod_r};
		for (int i = 0; i < NCH; i++) begin
			if (ch_rd_hit[i])
				rd_mux = ch_rd_data[i];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= r_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock source and prescaler

	// Edges are taken past the second stage only, so the first stage can
	// settle; an external clock must stay at or below half of aclk.
	wire fix_edge = fix_s_r[1] && !fix_s_r[2];
	wire ext_edge = ext_s_r[1] && !ext_s_r[2];

	logic src_tick;
	always_comb begin
		case (clks_r)
			CS_BUS:  src_tick = 1'b1;
			CS_FIX:  src_tick = fix_edge;
			CS_EXT:  src_tick = ext_edge;
			default: src_tick = 1'b0;
		endcase
	end

	// Only debug halts counting; wait mode has no effect here
	wire        run        = src_tick && !background_debug_mode;
	wire [7:0]  ps_one     = 8'h01 << ps_r;
	wire [6:0]  ps_mask    = ps_one[6:0] - 7'h01;
	wire        count_tick = run && ((pre_r & ps_mask) == ps_mask);

	////////////////////////////////////////////////////////////////////////
	// Counter

	wire        mod_free = (mod_r == CNT_ZERO) || (mod_r == CNT_FULL);
	wire [15:0] mod_top  = mod_free ? CNT_FULL : mod_r;
	wire        up_wrap  = (cnt_r == mod_top);
	wire        c_turn   = (dir_r == DIR_UP) && (cnt_r >= mod_r);
	wire        tof_set  = count_tick && !cnt_wr && (center_align_select_r ? c_turn : up_wrap);

	always_comb begin
		cnt_nxt = cnt_r;
		dir_nxt = dir_r;
		if (cnt_wr) begin
			cnt_nxt = CNT_ZERO;
			dir_nxt = DIR_UP;
		end else if (count_tick) begin
			if (!center_align_select_r) begin
				dir_nxt = DIR_UP;
				cnt_nxt = up_wrap ? CNT_ZERO : cnt_r + 16'h0001;
			end else if (c_turn) begin
				dir_nxt = DIR_DOWN;
				cnt_nxt = (cnt_r == CNT_ZERO) ? CNT_ZERO : cnt_r - 16'h0001;
			end else if (dir_r == DIR_UP) begin
				cnt_nxt = cnt_r + 16'h0001;
			end else begin
				cnt_nxt = (cnt_r == CNT_ZERO) ? CNT_ZERO : cnt_r - 16'h0001;
				if (cnt_r <= 16'h0001)
					dir_nxt = DIR_UP;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r     <= CNT_ZERO;
			dir_r     <= DIR_UP;
			pre_r     <= 7'h00;
			upd_r     <= 1'b0;
			step_up_r <= 1'b1;
			fix_s_r   <= 3'h0;
			ext_s_r   <= 3'h0;
		end else begin
			fix_s_r   <= {fix_s_r[1:0], fixed_clk_in};
			ext_s_r   <= {ext_s_r[1:0], external_count_clock};
			cnt_r     <= cnt_nxt;
			dir_r     <= dir_nxt;
			upd_r     <= count_tick && !cnt_wr;
			step_up_r <= (dir_r == DIR_UP) && !c_turn;
			if (cnt_wr)
				pre_r <= 7'h00;
			else if (run)
				pre_r <= pre_r + 7'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Global registers; reset leaves the clock off and nothing enabled

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tof_r   <= 1'b0;
			toie_r  <= 1'b0;
			center_align_select_r <= 1'b0;
			clks_r  <= CS_OFF;
			ps_r    <= 3'h0;
			mod_r   <= CNT_ZERO;
		end else begin
			tof_r <= tof_set || (tof_r && !(sc_wr && wdata_r[SC_TOF]));
			if (sc_wr) begin
				toie_r  <= wdata_r[SC_TOIE];
				center_align_select_r <= wdata_r[SC_CENTER_ALIGN_SELECT];
				clks_r  <= wdata_r[SC_CLKS_LSB +: 2];
				ps_r    <= wdata_r[SC_PS_LSB +: 3];
			end
			if (do_wr && w_mod)
				mod_r <= ptm_merge16(mod_r, wd16, ws16);
		end
	end

	assign tc_irq = tof_r && toie_r;

	////////////////////////////////////////////////////////////////////////
	// Channels

	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic        ie_r;
		logic [1:0]  ms_r;
		logic [1:0]  els_r;
		logic [15:0] val;
		logic        flag;

		wire in_blk  = (awaddr_r[7:3] == 5'(ADDR_CH_BASE[7:3] + i));
		wire rin_blk = (araddr[7:3] == 5'(ADDR_CH_BASE[7:3] + i));
		assign ch_wr_ctrl[i] = in_blk && (awaddr_r[2:0] == CH_CTRL_OFS);
		assign ch_wr_val[i]  = in_blk && (awaddr_r[2:0] == CH_VAL_OFS);
		assign ch_rd_hit[i]  = rin_blk &&
			((araddr[2:0] == CH_CTRL_OFS) || (araddr[2:0] == CH_VAL_OFS));
		assign ch_rd_data[i] = (araddr[2:0] == CH_VAL_OFS) ? {16'h0000, val} :
			{24'h000000, flag, ie_r, ms_r, els_r, 2'h0};

		wire ctrl_wr = do_wr && ch_wr_ctrl[i] && wstrb_r[0];

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				ie_r  <= 1'b0;
				ms_r  <= MS_IC;
				els_r <= ELS_OFF;
			end else if (ctrl_wr) begin
				ie_r  <= wdata_r[CH_IE];
				ms_r  <= wdata_r[CH_MS_LSB +: 2];
				els_r <= wdata_r[CH_ELS_LSB +: 2];
			end
		end

		ptm_chan u_chan (
			.aclk        (aclk),
			.aresetn     (aresetn),
			.count_value (cnt_r),
			.count_upd   (upd_r),
			.step_up     (step_up_r),
			.center      (center_align_select_r),
			.clock_on    (clks_r != CS_OFF),
			.mode        (ms_r),
			.els         (els_r),
			.val_wr      (do_wr && ch_wr_val[i]),
			.val_wdata   (wd16),
			.val_wstrb   (ws16),
			.flag_clr    (ctrl_wr && wdata_r[CH_FLAG]),
			.pin_in      (pin_in[i]),
			.pin_out     (channel_pin[i]),
			.pin_oe_n    (channel_pin_oe_n[i]),
			.chan_value  (val),
			.chan_flag   (flag)
		);

		assign chan_irq[i] = flag && ie_r;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_free_wrap: assert property (
		(!center_align_select_r && count_tick && mod_free && cnt_r == CNT_FULL && !cnt_wr)
		|=> (cnt_r == CNT_ZERO) && tof_r)
		else $error("free-running counter did not wrap");
	a_mod_wrap: assert property (
		(!center_align_select_r && count_tick && !mod_free && cnt_r == mod_r && !cnt_wr)
		|=> (cnt_r == CNT_ZERO) && tof_r)
		else $error("modulo wrap missed");
	a_cnt_clear: assert property (
		cnt_wr |=> (cnt_r == CNT_ZERO))
		else $error("count write did not clear");
	a_bdm_hold: assert property (
		(background_debug_mode && !cnt_wr) |=> $stable(cnt_r))
		else $error("counter moved in debug");
	a_div_two: assert property (
		(count_tick && ps_r == 3'h1 && clks_r == CS_BUS)
		|=> (!count_tick || ps_r != 3'h1))
		else $error("divide by two ticked twice");
	a_center_turn: assert property (
		(center_align_select_r && count_tick && dir_r == DIR_UP && cnt_r == mod_r &&
		mod_r != CNT_ZERO && !cnt_wr)
		|=> (dir_r == DIR_DOWN) && (cnt_r == $past(mod_r) - 16'h0001))
		else $error("center count did not turn");
	a_off_idle: assert property (
		(clks_r == CS_OFF) |-> (&channel_pin_oe_n))
		else $error("pin driven with clock off");
	a_read_quiet: assert property (
		(arvalid && arready && !count_tick && !cnt_wr) |=> $stable(cnt_r))
		else $error("read disturbed counter");

endmodule

// File: ptm_pins.sv
/*
 Pin-side partner of the pulse timer: resolves every channel pin and
 makes the external count clock. Assumes the bench sets the port level.
*/
`timescale 1ns/1ps
module ptm_pins #(
	parameter int NCH = 8
)
(
	// Clock
	input  wire logic           aclk,
	// Timer side
	input  wire logic [NCH-1:0] channel_pin,
	input  wire logic [NCH-1:0] channel_pin_oe_n,
	output logic      [NCH-1:0] pin_in,
	// Port side
	input  wire logic [NCH-1:0] gpio_level,
	output logic                ext_clk
);
	logic [1:0] div_r;

	// A released pin shows the port level, never the last timer level
	assign pin_in = (channel_pin_oe_n & gpio_level) | (~channel_pin_oe_n & channel_pin);
	// Quarter of the bus rate, half the fastest the synchronizer can follow
	assign ext_clk = div_r[1];
	initial div_r = 2'h0;
	always @(posedge aclk) div_r <= div_r + 2'h1;
endmodule

// File: ptm_top_tb.sv
/*
 Self-checking bench for the pulse timer: AXI4-Lite register tasks and
 directed scenarios. Assumes ptm_pkg and the ptm_pins partner model.
*/
`timescale 1ns/1ps
module ptm_top_tb
	import ptm_pkg::*;
;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, fixed_clk_in, ext_clk, dbg, tc_irq;
	logic [7:0]  awaddr, araddr, pin_in, chan_pin, oe_n, chan_irq, gpio;
	logic [31:0] wdata, rdata, v, x;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, fdiv;
	logic [31:0] lo [4] = '{32'h0, 32'h4E, 32'h8, 32'h12};
	logic [31:0] hi [4] = '{32'h0, 32'h54, 32'hC, 32'h16};
	int          fails, checks_done, ha, hb, eq;

	ptm_top #(.NCH(8)) dut (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .fixed_clk_in, .external_count_clock(ext_clk), .background_debug_mode(dbg),
		.pin_in, .channel_pin(chan_pin), .channel_pin_oe_n(oe_n), .chan_irq, .tc_irq
	);
	ptm_pins #(.NCH(8)) pins (
		.aclk, .channel_pin(chan_pin), .channel_pin_oe_n(oe_n), .pin_in, .gpio_level(gpio),
		.ext_clk
	);

	initial begin
		aclk = 1'h0;
		forever #5 aclk = ~aclk;
	end
	// Slow fixed clock, one rising edge every eight bus cycles
	always @(posedge aclk) begin
		fdiv <= fdiv + 2'h1;
		if (fdiv == 2'h3)
			fixed_clk_in <= ~fixed_clk_in;
	end

	////////////////////////////////////////////////////////////////
	function automatic logic [7:0] cc(input int i);
		return ADDR_CH_BASE + 8'(8 * i) + 8'(CH_CTRL_OFS);
	endfunction
	function automatic logic [7:0] cv(input int i);
		return ADDR_CH_BASE + 8'(8 * i) + 8'(CH_VAL_OFS);
	endfunction
	function automatic logic [31:0] scv(input int ie, cp, cs, ps);
		return 32'((ie << SC_TOIE) | (cp << SC_CENTER_ALIGN_SELECT) | (cs << SC_CLKS_LSB) | ps);
	endfunction
	function automatic logic [31:0] ccv(input int ie, ms, els);
		return 32'((ie << CH_IE) | (ms << CH_MS_LSB) | (els << CH_ELS_LSB));
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] l, input logic [31:0] h);
		checks_done++;
		if ((got >= l && got <= h) !== 1'h1) begin
			fails++;
			$display("BAD %0t got %h want %h..%h", $time, got, l, h);
		end
	endtask

	// Handshakes are sampled at the falling edge, where nothing moves
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er = RESP_OKAY, input logic [3:0] st = 4'hF);
		logic ta, tw, tb;
		logic [1:0] r;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= st;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		tb = 1'h0;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid & bready;
			r = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'h0;
			if (tw)
				wvalid <= 1'h0;
			if (tb)
				bready <= 1'h0;
		end
		chk(32'(r), 32'(er), 32'(er));
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er = RESP_OKAY);
		logic ta, tb;
		logic [1:0] r;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		tb = 1'h0;
		while (!tb) begin
			@(negedge aclk);
			ta = arvalid & arready;
			tb = rvalid & rready;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'h0;
			if (tb)
				rready <= 1'h0;
		end
		chk(32'(r), 32'(er), 32'(er));
	endtask

	task automatic reset_dut();
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
	endtask

	// Counts high cycles of two pins and the cycles where they agree
	task automatic pwm(input int a, input int b, input int win);
		ha = 0;
		hb = 0;
		eq = 0;
		repeat (win) begin
			@(negedge aclk);
			ha += int'(chan_pin[a]);
			hb += int'(chan_pin[b]);
			eq += int'(chan_pin[a] === chan_pin[b]);
		end
	endtask

	// Runs the counter from zero for cyc cycles, then freezes and reads it
	task automatic measure(input int cs, input int ps, input int cyc,
		input logic [31:0] l, input logic [31:0] h);
		wr(ADDR_SC, 32'h0);
		wr(ADDR_CNT, 32'h0);
		wr(ADDR_SC, scv(0, 0, cs, ps));
		repeat (cyc) @(posedge aclk);
		dbg <= 1'h1;
		rd(ADDR_CNT, x);
		chk(x, l, h);
		repeat (5) @(posedge aclk);
		rd(ADDR_CNT, v);
		chk(v, x, x);
		// Upper byte only: any byte of the count must clear it
		wr(ADDR_CNT, 32'h0000A5A5, RESP_OKAY, 4'h2);
		rd(ADDR_CNT, v);
		chk(v, 32'h0, 32'h0);
		dbg <= 1'h0;
	endtask

	task automatic close_out();
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (40000) @(posedge aclk);
		fails++;
		close_out();
	end

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, dbg} = 7'h0;
		{awaddr, araddr, gpio, wdata, wstrb} = '0;
		{fixed_clk_in, fdiv} = 3'h0;
		fails = 0;
		checks_done = 0;
		reset_dut();
		rd(ADDR_SC, v);
		chk(v, 32'h0, 32'h0);
		chk(32'({oe_n, chan_irq, tc_irq}), 32'h1FE00, 32'h1FE00);
		wr(8'hFC, 32'h1, RESP_SLVERR);
		rd(8'hFC, v, RESP_SLVERR);
		for (int n = 0; n < 8; n++)
			measure(1, n, 8 << n, 32'h7, 32'hC);
		wr(ADDR_MOD, 32'hFFFF);
		for (int s = 0; s < 4; s++)
			measure(s, 0, 80, lo[s], hi[s]);
		repeat (20) @(posedge aclk);
		rd(ADDR_CNT, v);
		chk(v, 32'h2, 32'hC);
		// Terminal count with a short modulo
		wr(ADDR_MOD, 32'h9);
		wr(ADDR_SC, scv(1, 0, 1, 0));
		repeat (30) @(posedge aclk);
		@(negedge aclk);
		chk(32'(tc_irq), 32'h1, 32'h1);
		rd(ADDR_CNT, v);
		chk(v, 32'h0, 32'h9);
		dbg <= 1'h1;
		wr(ADDR_SC, scv(1, 0, 1, 0) | 32'h80);
		rd(ADDR_SC, v);
		chk(v, scv(1, 0, 1, 0), scv(1, 0, 1, 0));
		chk(32'(tc_irq), 32'h0, 32'h0);
		dbg <= 1'h0;
		// Compare: set, clear, toggle and flag only on four channels
		reset_dut();
		wr(ADDR_MOD, 32'h14);
		for (int i = 0; i < 4; i++) begin
			wr(cc(i), ccv(1, MS_OC, 3 - i));
			wr(cv(i), 32'h5);
		end
		chk(32'(oe_n), 32'hFF, 32'hFF);
		wr(ADDR_SC, scv(0, 0, 1, 0));
		repeat (15) @(posedge aclk);
		@(negedge aclk);
		chk(32'(chan_pin[2:0]), 32'h5, 32'h5);
		chk(32'(oe_n[3:0]), 32'h8, 32'h8);
		chk(32'(chan_irq[3:0]), 32'hF, 32'hF);
		// Edge-aligned pair of opposite polarity
		reset_dut();
		wr(ADDR_MOD, 32'h8);
		wr(cc(4), ccv(1, 2, 2));
		wr(cc(5), ccv(0, 2, 1));
		wr(cv(4), 32'h5);
		wr(cv(5), 32'h5);
		wr(ADDR_SC, scv(0, 0, 1, 0));
		repeat (20) @(posedge aclk);
		pwm(4, 5, 36);
		chk(32'(ha), 32'h14, 32'h14);
		chk(32'(hb), 32'h10, 32'h10);
		chk(32'(eq), 32'h0, 32'h0);
		rd(cc(4), v);
		chk(32'(v[CH_FLAG]), 32'h1, 32'h1);
		rd(ADDR_SC, v);
		chk(32'(v[SC_TOF]), 32'h1, 32'h1);
		// Center mode overrides a capture setting
		reset_dut();
		wr(ADDR_MOD, 32'h8);
		wr(cc(6), ccv(0, MS_IC, 2));
		wr(cv(6), 32'h5);
		wr(ADDR_SC, scv(0, 1, 1, 0));
		repeat (20) @(posedge aclk);
		pwm(6, 6, 32);
		chk(32'(ha), 32'h14, 32'h14);
		chk(32'(oe_n[6]), 32'h0, 32'h0);
		// Capture against a frozen count
		reset_dut();
		wr(cc(7), ccv(1, MS_IC, 1));
		wr(ADDR_SC, scv(0, 0, 1, 0));
		repeat (20) @(posedge aclk);
		dbg <= 1'h1;
		rd(ADDR_CNT, x);
		gpio[7] <= 1'h1;
		repeat (4) @(posedge aclk);
		rd(cv(7), v);
		chk(v, x, x);
		chk(32'({chan_irq[7], oe_n[7]}), 32'h3, 32'h3);
		close_out();
	end
endmodule
